// file: include/drc_pkg.sv
// drc_pkg: shared constants and types for the dram address mux/strobe driver pair
// assumes: single 25 MHz clock, all pins sampled synchronously
package drc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned MODE_SETTLE_NS  = 30;
  localparam int unsigned CS_SETUP_NS     = 30;
  localparam int unsigned CS_HOLD_NS      = 15;
  localparam int unsigned RAS_STRETCH_NS  = 25;
  localparam int unsigned RK_TO_RAS_NS    = 50;
  localparam int unsigned ROW_HOLD_NS     = 13;
  localparam int unsigned COL_SETUP_NS    = 13;
  localparam int unsigned MODE_SETTLE_CYC = (MODE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CS_SETUP_CYC    = (CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CS_HOLD_CYC     = (CS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RAS_STRETCH_CYC = (RAS_STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RK_TO_RAS_CYC   = (RK_TO_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ROW_HOLD_CYC    = (ROW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned COL_SETUP_CYC   = (COL_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // widths, counts, reset values
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 9;
  localparam logic [8:0]  EOC_127     = 9'h07f;
  localparam logic [8:0]  EOC_255     = 9'h0ff;
  localparam logic [8:0]  EOC_511     = 9'h1ff;
  localparam logic [8:0]  CNT_RST     = 9'h000;
  localparam logic [3:0]  RAS_IDLE    = 4'hf;
  localparam logic [2:0]  TMR_W0      = 3'h0;

  // mode codes on the three mode pins
  localparam logic [2:0]  MODE_EXT_REF  = 3'h0;
  localparam logic [2:0]  MODE_AUTO_REF = 3'h1;
  localparam logic [2:0]  MODE_BURST    = 3'h2;
  localparam logic [2:0]  MODE_EXT_ACC  = 3'h4;
  localparam logic [2:0]  MODE_AUTO_ACC = 3'h5;

  // end-of-count select
  localparam logic [1:0]  EOC_SEL_127 = 2'h0;
  localparam logic [1:0]  EOC_SEL_255 = 2'h1;
  localparam logic [1:0]  EOC_SEL_511 = 2'h2;

  typedef enum logic [1:0] {
    DRC_H_IDLE,
    DRC_H_ROW,
    DRC_H_COL,
    DRC_H_DONE
  } drc_hstate_e;

endpackage

// file: include/drc_if.sv
// drc_if: pins between the dram controller and its processor-side sequencer
// assumes: clock and reset come from the bench; refresh_io is open drain
`timescale 1ns/1ps
`default_nettype none
interface drc_if (
  input wire logic clk,
  input wire logic rst
);
  logic [2:0] mode;
  logic [1:0] eoc_sel;
  logic       row_strobe_in;
  logic       col_strobe_in;
  logic       row_col_select;
  logic       chip_select_n;
  logic       refresh_period_clock;
  logic       address_latch_strobe;
  logic       bank_sel_low;
  logic       bank_sel_high;
  logic [8:0] row_addr;
  logic [8:0] col_addr;
  logic [8:0] addr_out;
  logic [3:0] ras_out_n;
  logic       cas_out_n;
  logic       refresh_io_o;
  logic       refresh_io_oe;
  logic       refresh_io_i;

  assign refresh_io_i = refresh_io_oe ? refresh_io_o : 1'b1;

  modport dev (
    input  mode, eoc_sel, row_strobe_in, col_strobe_in, row_col_select, chip_select_n,
           refresh_period_clock, address_latch_strobe, bank_sel_low, bank_sel_high,
           row_addr, col_addr, refresh_io_i,
    output addr_out, ras_out_n, cas_out_n, refresh_io_o, refresh_io_oe
  );
  modport host (
    output mode, eoc_sel, row_strobe_in, col_strobe_in, row_col_select, chip_select_n,
           refresh_period_clock, address_latch_strobe, bank_sel_low, bank_sel_high,
           row_addr, col_addr,
    input  addr_out, ras_out_n, cas_out_n, refresh_io_i
  );
endinterface
`default_nettype wire

// file: logic/drc_dev.sv
// drc_dev: dram address multiplexer, refresh counter and strobe driver
// assumes: all pins synchronous to clk; host keeps its own timing rules
//
// Contract
// - refresh modes: refresh pin flags end-of-count
// - end-of-count selectable 127, 255 or 511
// - counter always counts to 511 then wraps
// - host holds strobe or select high entering mode5
// - host waits 30 ns before access strobe
// - mode0 host stretches row strobe by 25 ns
// - select leads strobe 30 ns, trails 15 ns
// - mode5 unselected strobe is hidden refresh
// - hidden refresh when period clock high
// - no forced refresh after hidden refresh
// - host ignores refresh pin while strobe low
// - host disables hidden refresh at fast clocks
// - disable: select tied low, select ORed strobe
// - period clock rise 50 ns before strobe
// - mode4 order: row strobe, select, column strobe
// - select follows row strobe by hold margin
// - column strobe follows select by setup margin
// - address inputs latched on latch strobe fall
// - bank bits pick one of four row strobes
`timescale 1ns/1ps
`default_nettype none
module drc_dev (
  input wire logic clk,
  input wire logic rst,
  drc_if.dev       pins
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [8:0] row_lat;
    logic [8:0] col_lat;
    logic [1:0] bank_lat;
    logic       als_prev;
    logic       ras_prev;
    logic       rk_prev;
    logic [8:0] cnt;
    logic       in_ref;
    logic       hidden;
    logic       hid_done;
    logic       force_req;
    logic [8:0] addr;
    logic [3:0] ras_n;
    logic       cas_n;
    logic       rfio_o;
    logic       rfio_oe;
  } drc_dev_s;

  drc_dev_s s_q;
  drc_dev_s s_d;

  function automatic logic [8:0] eoc_val(input logic [1:0] sel);
    case (sel)
      drc_pkg::EOC_SEL_127: eoc_val = drc_pkg::EOC_127;
      drc_pkg::EOC_SEL_255: eoc_val = drc_pkg::EOC_255;
      default:              eoc_val = drc_pkg::EOC_511;
    endcase
  endfunction

  function automatic logic [3:0] bank_dec(input logic [1:0] b);
    bank_dec = ~(4'h1 << b);
  endfunction

  logic is_ref;
  logic ras_fall;
  logic ras_rise;
  logic rk_rise;
  assign is_ref   = ~pins.mode[2];
  assign ras_fall = s_q.ras_prev & ~pins.row_strobe_in;
  assign ras_rise = ~s_q.ras_prev & pins.row_strobe_in;
  assign rk_rise  = ~s_q.rk_prev & pins.refresh_period_clock;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.als_prev = pins.address_latch_strobe;
    s_d.ras_prev = pins.row_strobe_in;
    s_d.rk_prev  = pins.refresh_period_clock;
    if (s_q.als_prev && !pins.address_latch_strobe)
    begin
      s_d.row_lat  = pins.row_addr;
      s_d.col_lat  = pins.col_addr;
      s_d.bank_lat = {pins.bank_sel_high, pins.bank_sel_low};
    end
    // period bookkeeping
    if (rk_rise)
    begin
      s_d.hid_done  = 1'b0;
      s_d.force_req = 1'b0;
    end
    // strobe falls: refresh, hidden refresh or access
    if (ras_fall)
    begin
      if (is_ref)
      begin
        s_d.in_ref = 1'b1;
        s_d.ras_n  = 4'h0;
      end
      else if (pins.mode == drc_pkg::MODE_AUTO_ACC && pins.chip_select_n
               && pins.refresh_period_clock)
      begin
        s_d.hidden   = 1'b1;
        s_d.hid_done = 1'b1;
        s_d.ras_n    = 4'h0;
      end
      else if (!pins.chip_select_n)
        s_d.ras_n = bank_dec(s_q.bank_lat);
    end
    if (ras_rise)
    begin
      s_d.ras_n = drc_pkg::RAS_IDLE;
      if (s_q.in_ref || s_q.hidden)
        s_d.cnt = s_q.cnt + 9'h001;
      s_d.in_ref = 1'b0;
      s_d.hidden = 1'b0;
    end
    // forced request at period clock fall, unless a hidden refresh ran
    if (s_q.rk_prev && !pins.refresh_period_clock && pins.mode == drc_pkg::MODE_AUTO_ACC
        && !s_q.hid_done && !s_d.hid_done)
      s_d.force_req = 1'b1;
    // column strobe
    if (pins.mode == drc_pkg::MODE_EXT_ACC)
      s_d.cas_n = pins.col_strobe_in | pins.row_strobe_in;
    else if (pins.mode == drc_pkg::MODE_AUTO_ACC)
      s_d.cas_n = ~(~s_q.ras_n[0] | ~s_q.ras_n[1] | ~s_q.ras_n[2] | ~s_q.ras_n[3])
                  | s_q.hidden | pins.row_strobe_in;
    else
      s_d.cas_n = 1'b1;
    // address source
    if (is_ref || s_d.hidden)
      s_d.addr = s_q.cnt;
    else if (pins.mode == drc_pkg::MODE_EXT_ACC)
      s_d.addr = pins.row_col_select ? s_q.row_lat : s_q.col_lat;
    else
      s_d.addr = (s_q.ras_n != drc_pkg::RAS_IDLE && !s_q.hidden) ? s_q.col_lat : s_q.row_lat;
    // refresh pin
    if (is_ref)
    begin
      s_d.rfio_oe = (s_q.cnt == eoc_val(pins.eoc_sel));
      s_d.rfio_o  = 1'b0;
    end
    else
    begin
      s_d.rfio_oe = s_d.force_req;
      s_d.rfio_o  = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q       <= '0;
      s_q.als_prev <= 1'b1;
      s_q.ras_prev <= 1'b1;
      s_q.ras_n <= drc_pkg::RAS_IDLE;
      s_q.cas_n <= 1'b1;
      s_q.rfio_o <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pins.addr_out      = s_q.addr;
  assign pins.ras_out_n     = s_q.ras_n;
  assign pins.cas_out_n     = s_q.cas_n;
  assign pins.refresh_io_o  = s_q.rfio_o;
  assign pins.refresh_io_oe = s_q.rfio_oe;

endmodule
`default_nettype wire

// file: logic/drc_host.sv
// drc_host: processor-side sequencer driving the dram controller pins
// assumes: one request pulse at a time; user holds address until done
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module drc_host (
  input  wire logic       clk,
  input  wire logic       rst,
  drc_if.host             pins,
  input  wire logic [2:0] cfg_mode,
  input  wire logic [1:0] cfg_eoc_sel,
  input  wire logic       cfg_hidden_off,
  input  wire logic       req,
  input  wire logic [8:0] req_row,
  input  wire logic [8:0] req_col,
  input  wire logic [1:0] req_bank,
  input  wire logic       period_tick,
  output var  logic       busy,
  output var  logic       eoc_seen
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    drc_pkg::drc_hstate_e st;
    logic [2:0] tmr;
    logic [2:0] mode;
    logic       ras;
    logic       cas;
    logic       rc;
    logic       cs_n;
    logic       als;
    logic       rk;
    logic       busy;
    logic       eoc;
    logic [8:0] row;
    logic [8:0] col;
    logic [1:0] bank;
  } drc_host_s;

  drc_host_s s_q;
  drc_host_s s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.eoc = ~pins.refresh_io_i & s_q.ras;
    if (period_tick)
      s_d.rk = ~s_q.rk;
    if (cfg_mode != s_q.mode && s_q.st == drc_pkg::DRC_H_IDLE)
    begin
      s_d.mode = cfg_mode;
      s_d.cas  = 1'b1;
      s_d.rc   = 1'b1;
      s_d.tmr  = 3'(drc_pkg::MODE_SETTLE_CYC);
    end
    else
    case (s_q.st)
      drc_pkg::DRC_H_IDLE:
      begin
        if (s_q.tmr != drc_pkg::TMR_W0)
          s_d.tmr = s_q.tmr - 3'h1;
        else if (req)
        begin
          s_d.busy = 1'b1;
          s_d.row  = req_row;
          s_d.col  = req_col;
          s_d.bank = req_bank;
          s_d.als  = 1'b0;
          s_d.cs_n = 1'b0;
          s_d.tmr  = 3'(drc_pkg::CS_SETUP_CYC);
          s_d.st   = drc_pkg::DRC_H_ROW;
        end
        // hidden refresh on period clock rise, select left high
        else if (period_tick && !s_q.rk && s_q.mode == drc_pkg::MODE_AUTO_ACC && !cfg_hidden_off)
        begin
          s_d.busy = 1'b1;
          s_d.tmr  = 3'(drc_pkg::RK_TO_RAS_CYC);
          s_d.st   = drc_pkg::DRC_H_ROW;
        end
      end
      drc_pkg::DRC_H_ROW:
      begin
        if (s_q.tmr != drc_pkg::TMR_W0)
          s_d.tmr = s_q.tmr - 3'h1;
        else if (s_q.ras)
        begin
          s_d.ras = 1'b0;
          s_d.tmr = 3'(drc_pkg::ROW_HOLD_CYC + drc_pkg::RAS_STRETCH_CYC);
        end
        else
        begin
          s_d.rc  = 1'b0;
          s_d.tmr = 3'(drc_pkg::COL_SETUP_CYC);
          s_d.st  = drc_pkg::DRC_H_COL;
        end
      end
      drc_pkg::DRC_H_COL:
      begin
        if (s_q.tmr != drc_pkg::TMR_W0)
          s_d.tmr = s_q.tmr - 3'h1;
        else if (s_q.cas)
        begin
          s_d.cas = 1'b0;
          s_d.tmr = 3'h1;
        end
        else
        begin
          s_d.ras = 1'b1;
          s_d.cas = 1'b1;
          s_d.rc  = 1'b1;
          s_d.als = 1'b1;
          s_d.tmr = 3'(drc_pkg::CS_HOLD_CYC);
          s_d.st  = drc_pkg::DRC_H_DONE;
        end
      end
      drc_pkg::DRC_H_DONE:
      begin
        if (s_q.tmr != drc_pkg::TMR_W0)
          s_d.tmr = s_q.tmr - 3'h1;
        else
        begin
          s_d.cs_n = cfg_hidden_off ? 1'b0 : 1'b1;
          s_d.busy = 1'b0;
          s_d.st   = drc_pkg::DRC_H_IDLE;
        end
      end
      default:
        s_d.st = drc_pkg::DRC_H_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q      <= '0;
      s_q.st   <= drc_pkg::DRC_H_IDLE;
      s_q.ras  <= 1'b1;
      s_q.cas  <= 1'b1;
      s_q.rc   <= 1'b1;
      s_q.cs_n <= 1'b1;
      s_q.als  <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  assign pins.mode                 = s_q.mode;
  assign pins.eoc_sel              = cfg_eoc_sel;
  assign pins.row_strobe_in        = s_q.ras | (cfg_hidden_off & s_q.cs_n);
  assign pins.col_strobe_in        = s_q.cas;
  assign pins.row_col_select       = s_q.rc;
  assign pins.chip_select_n        = cfg_hidden_off ? 1'b0 : s_q.cs_n;
  assign pins.refresh_period_clock = s_q.rk;
  assign pins.address_latch_strobe = s_q.als;
  assign pins.bank_sel_low         = s_q.bank[0];
  assign pins.bank_sel_high        = s_q.bank[1];
  assign pins.row_addr             = s_q.row;
  assign pins.col_addr             = s_q.col;
  assign busy                      = s_q.busy;
  assign eoc_seen                  = s_q.eoc;

endmodule
`default_nettype wire

// file: dv/drc_asserts.sv
// drc_asserts: pin timing checks between host sequencer and dram controller
// assumes: one clock, async active-high reset, instantiated beside drc_if
`timescale 1ns/1ps
`default_nettype none
module drc_checker (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [2:0] mode,
  input wire logic [1:0] eoc_sel,
  input wire logic       row_strobe_in,
  input wire logic       col_strobe_in,
  input wire logic       row_col_select,
  input wire logic       chip_select_n,
  input wire logic       refresh_period_clock,
  input wire logic [8:0] col_addr,
  input wire logic [8:0] addr_out,
  input wire logic [3:0] ras_out_n,
  input wire logic       cas_out_n,
  input wire logic       refresh_io_i
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic       hid_q;
  logic       hid_d;
  logic       rsi_q;
  logic       rck_q;
  logic       refm;
  logic [8:0] eoc_v;

  assign refm  = (mode <= drc_pkg::MODE_BURST);
  assign eoc_v = (eoc_sel == drc_pkg::EOC_SEL_127) ? drc_pkg::EOC_127 :
                 (eoc_sel == drc_pkg::EOC_SEL_255) ? drc_pkg::EOC_255 : drc_pkg::EOC_511;

  // hidden refresh seen in this period clock period
  always_comb
  begin
    hid_d = hid_q;
    if (mode != drc_pkg::MODE_AUTO_ACC || (refresh_period_clock && !rck_q))
      hid_d = 1'b0;
    else if (chip_select_n && refresh_period_clock && rsi_q && !row_strobe_in)
      hid_d = 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hid_q <= 1'b0;
      rsi_q <= 1'b1;
      rck_q <= 1'b0;
    end
    else
    begin
      hid_q <= hid_d;
      rsi_q <= row_strobe_in;
      rck_q <= refresh_period_clock;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_REF_ALL_RAS: assert property (refm && $fell(row_strobe_in) |=> ras_out_n == 4'h0)
    else $error("refresh strobe did not pull all row strobes");
  AST_CNT_STEP: assert property (refm && $rose(row_strobe_in) |-> ##2 addr_out == 9'($past(addr_out, 2) + 9'h001))
    else $error("refresh count did not step by one");
  AST_EOC_FLAG: assert property (refm && $stable(mode) && row_strobe_in && !refresh_io_i |-> addr_out == eoc_v)
    else $error("end of count flag away from end of count");
  AST_ACC_ONE_RAS: assert property (mode == drc_pkg::MODE_AUTO_ACC && !chip_select_n && $fell(row_strobe_in)
    |=> $countones(ras_out_n) == 3)
    else $error("access did not drive exactly one row strobe");
  AST_HIDDEN: assert property (mode == drc_pkg::MODE_AUTO_ACC && chip_select_n && refresh_period_clock
    && $fell(row_strobe_in) |=> ras_out_n == 4'h0)
    else $error("hidden refresh not carried out");
  AST_NO_FORCED: assert property (hid_q && mode == drc_pkg::MODE_AUTO_ACC |-> refresh_io_i)
    else $error("forced request after hidden refresh");
  AST_RAS_IDLE: assert property (row_strobe_in && $past(row_strobe_in) |-> ras_out_n == drc_pkg::RAS_IDLE)
    else $error("row strobe low without strobe input");
  AST_COL4: assert property (mode == drc_pkg::MODE_EXT_ACC && $fell(row_col_select) |=> addr_out == col_addr)
    else $error("column address not switched in");
  AST_CAS4: assert property (mode == drc_pkg::MODE_EXT_ACC && $fell(col_strobe_in) |=> !cas_out_n)
    else $error("column strobe not produced");

  cover property (mode == drc_pkg::MODE_AUTO_ACC && !chip_select_n && $fell(row_strobe_in));
  cover property (refm && $fell(row_strobe_in));
  cover property (mode == drc_pkg::MODE_EXT_ACC && $fell(col_strobe_in));
  cover property (!refresh_io_i);
endmodule
`default_nettype wire

// file: dv/test_drc.sv
// test_drc: host sequencer against dram controller, checked at the pins
// assumes: both ends meet in drc_if; 25 MHz clock; reset held 4 cycles
`timescale 1ns/1ps
`default_nettype none
module test_drc;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] cfg_mode = 3'h0;
  logic [1:0] cfg_eoc_sel = 2'h0;
  logic       cfg_hidden_off = 1'b0;
  logic       req = 1'b0;
  logic [8:0] req_row = 9'h000;
  logic [8:0] req_col = 9'h000;
  logic [1:0] req_bank = 2'h0;
  logic       period_tick = 1'b0;
  logic       busy;
  logic       eoc_seen;
  logic       got = 1'b0;
  logic       cs_hi = 1'b0;
  logic [3:0] ras_seen = 4'hf;
  logic [8:0] addr_ras = 9'h000;
  logic [8:0] addr_cas = 9'h000;
  int         n_mismatch = 0;
  int         compares = 0;

  always #20 clk = ~clk;

  drc_if u_drc_if (.clk(clk), .rst(rst));
  drc_dev u_drc_dev (.clk(clk), .rst(rst), .pins(u_drc_if));
  drc_host u_drc_host (.clk(clk), .rst(rst), .pins(u_drc_if), .cfg_mode(cfg_mode), .cfg_eoc_sel(cfg_eoc_sel),
    .cfg_hidden_off(cfg_hidden_off), .req(req), .req_row(req_row), .req_col(req_col), .req_bank(req_bank),
    .period_tick(period_tick), .busy(busy), .eoc_seen(eoc_seen));
  drc_checker u_drc_checker (.clk(clk), .rst(rst), .mode(u_drc_if.mode), .eoc_sel(u_drc_if.eoc_sel),
    .row_strobe_in(u_drc_if.row_strobe_in), .col_strobe_in(u_drc_if.col_strobe_in),
    .row_col_select(u_drc_if.row_col_select), .chip_select_n(u_drc_if.chip_select_n),
    .refresh_period_clock(u_drc_if.refresh_period_clock), .col_addr(u_drc_if.col_addr),
    .addr_out(u_drc_if.addr_out), .ras_out_n(u_drc_if.ras_out_n), .cas_out_n(u_drc_if.cas_out_n),
    .refresh_io_i(u_drc_if.refresh_io_i));

  // ----------------------------------------------------------------
  // pin monitor
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (u_drc_if.ras_out_n === 4'hf)
      got <= 1'b0;
    else if (!got)
    begin
      got <= 1'b1;
      ras_seen <= u_drc_if.ras_out_n;
      addr_ras <= u_drc_if.addr_out;
    end
    if (u_drc_if.cas_out_n === 1'b0)
      addr_cas <= u_drc_if.addr_out;
    if (cfg_hidden_off && u_drc_if.chip_select_n !== 1'b0)
      cs_hi <= 1'b1;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check_val(input string what, input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic do_reset;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic set_mode(input logic [2:0] m, input logic hoff);
    @(posedge clk);
    cfg_mode       <= m;
    cfg_hidden_off <= hoff;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic tick;
    @(posedge clk);
    period_tick <= 1'b1;
    @(posedge clk);
    period_tick <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic do_req(input logic [8:0] row, input logic [8:0] col, input logic [1:0] bank);
    int k;
    @(posedge clk);
    req      <= 1'b1;
    req_row  <= row;
    req_col  <= col;
    req_bank <= bank;
    @(posedge clk);
    req <= 1'b0;
    @(negedge clk);
    for (k = 0; k < 100 && busy !== 1'b0; k++)
      @(negedge clk);
    if (k == 100)
    begin
      n_mismatch++;
      close_out();
    end
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_access(input logic [2:0] m, input logic hoff);
    int b;
    set_mode(m, hoff);
    for (b = 0; b < 4; b++)
    begin
      do_req(9'h1a5 ^ 9'(b), 9'h05a + 9'(b), 2'(b));
      check_val("row strobes", {5'h00, ras_seen}, {5'h00, ~(4'h1 << b)});
      check_val("row address", addr_ras, 9'h1a5 ^ 9'(b));
      check_val("column address", addr_cas, 9'h05a + 9'(b));
    end
    if (hoff)
      check_val("select left low", {8'h00, cs_hi}, 9'h000);
  endtask

  task automatic t_forced;
    do_reset();
    set_mode(drc_pkg::MODE_AUTO_ACC, 1'b0);
    tick();
    tick();
    check_val("forced after hidden", {8'h00, u_drc_if.refresh_io_i}, 9'h001);
    set_mode(drc_pkg::MODE_AUTO_ACC, 1'b1);
    tick();
    tick();
    check_val("forced request", {8'h00, eoc_seen}, 9'h001);
    tick();
    check_val("forced request end", {8'h00, eoc_seen}, 9'h000);
  endtask

  task automatic t_refresh(input logic [1:0] sel, input int n, input logic [8:0] eoc);
    int i;
    do_reset();
    cfg_eoc_sel <= sel;
    set_mode(drc_pkg::MODE_EXT_REF, 1'b0);
    for (i = 0; i < n; i++)
    begin
      do_req(9'h000, 9'h000, 2'h0);
      check_val("refresh strobes", {5'h00, ras_seen}, 9'h000);
      check_val("refresh count", addr_ras, 9'(i));
      check_val("end of count", {8'h00, eoc_seen}, {8'h00, 9'(i + 1) == eoc});
    end
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_access(drc_pkg::MODE_AUTO_ACC, 1'b0);
    t_access(drc_pkg::MODE_AUTO_ACC, 1'b1);
    t_access(drc_pkg::MODE_EXT_ACC, 1'b0);
    t_forced();
    t_refresh(drc_pkg::EOC_SEL_127, 130, drc_pkg::EOC_127);
    t_refresh(drc_pkg::EOC_SEL_255, 258, drc_pkg::EOC_255);
    t_refresh(drc_pkg::EOC_SEL_511, 514, drc_pkg::EOC_511);
    close_out();
  end
endmodule
`default_nettype wire
